// [rtl/pcg_pkg.sv]
// Package for the programmable CRC generator: register map, field positions,
// reset values and the carrier types shared by the design files.
// Assumes an AHB-Lite bus with 32-bit data and one aligned word per register.
package pcg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] PCG_OFS_CTRL    = 8'h00;
    localparam logic [7:0] PCG_OFS_POLY    = 8'h04;
    localparam logic [7:0] PCG_OFS_DATA    = 8'h08;
    localparam logic [7:0] PCG_OFS_SEED    = 8'h0c;
    localparam logic [7:0] PCG_OFS_IRQ_STS = 8'h10;
    localparam logic [7:0] PCG_OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] PCG_OFS_IRQ_EN  = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in the control and status word and the interrupt registers
    localparam int PCG_IDLE_BIT  = 13;
    localparam int PCG_CNT_LSB   = 8;
    localparam int PCG_FULL_BIT  = 7;
    localparam int PCG_EMPTY_BIT = 6;
    localparam int PCG_RUN_BIT   = 4;
    localparam int PCG_PLEN_LSB  = 0;
    localparam int PCG_IRQ_DRAIN = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes and reset values
    localparam logic [4:0]  PCG_DEPTH_NARROW = 5'h10;
    localparam logic [4:0]  PCG_DEPTH_WIDE   = 5'h08;
    localparam logic [3:0]  PCG_PLEN_SPLIT   = 4'h7;
    localparam logic [15:0] PCG_TAP_MASK     = 16'hfffe;
    localparam logic [15:0] PCG_POLY_RST     = 16'h0000;
    localparam logic [15:0] PCG_CRC_RST      = 16'h0000;
    localparam logic [4:0]  PCG_CNT_RST      = 5'h00;
    localparam logic [31:0] PCG_RDATA_RST    = 32'h0000_0000;

    typedef struct packed {
        logic       idle_halt_select;
        logic       shifter_run;
        logic [3:0] poly_length_minus_one;
    } pcg_ctrl_t;

    localparam pcg_ctrl_t PCG_CTRL_RST = '0;

    // Captured AHB address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } pcg_aphase_t;

    localparam pcg_aphase_t PCG_APHASE_RST = '0;

endpackage

// [rtl/pcg_top.sv]
// Programmable CRC generator with word FIFO, serial LFSR and AHB-Lite slave.
// Assumes a single-master AHB-Lite bus on hclk; sleep_mode and idle_mode come
// from power control logic on the same clock.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

module pcg_top
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        sleep_mode,
    input  wire logic        idle_mode,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             crc_irq
);
    import pcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [4:0] fifo_max(input logic [3:0] plen);
        return (plen > PCG_PLEN_SPLIT) ? PCG_DEPTH_WIDE : PCG_DEPTH_NARROW;
    endfunction

    function automatic logic [15:0] plen_mask(input logic [3:0] plen);
        return 16'hffff >> (4'hf - plen);
    endfunction

    function automatic logic [15:0] lfsr_step(input logic [15:0] crc,
                                               input logic [15:0] taps,
                                               input logic [3:0]  plen,
                                               input logic        din);
        logic        fb;
        logic [15:0] nxt;
        fb  = crc[plen] ^ din;
        nxt = {crc[14:0], 1'b0} ^ (fb ? {taps[15:1], 1'b1} : 16'h0000);
        return nxt & plen_mask(plen);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    pcg_ctrl_t   ctrl_reg;
    pcg_aphase_t ap_reg;
    logic [15:0] poly_reg;
    logic [15:0] fifo_mem [16];
    logic [3:0]  wr_ptr_reg;
    logic [3:0]  rd_ptr_reg;
    logic [4:0]  count_reg;
    logic [4:0]  count_next;
    logic [3:0]  bit_idx_reg;
    logic [15:0] crc_reg;
    logic        active_reg;
    logic [0:0]  irq_sts_reg;
    logic [0:0]  irq_sts_next;
    logic [0:0]  irq_en_reg;
    logic        irq_reg;
    logic [31:0] hrdata_reg;
    logic        hready_reg;
    logic        hresp_reg;
    logic [31:0] rd_val;
    logic        take;
    logic        we_ctrl;
    logic        we_poly;
    logic        we_data;
    logic        we_seed;
    logic        we_clr;
    logic        we_en;
    logic        run_en;
    logic        advance;
    logic        pop;
    logic        push;
    logic        full;
    logic        empty;
    logic        wrap;
    logic        drain_evt;
    logic [3:0]  plen;
    logic        din;

    assign hrdata    = hrdata_reg;
    assign hreadyout = hready_reg;
    assign hresp     = hresp_reg;
    assign crc_irq   = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes zero wait, reads one wait state so that a read
    // right behind a write sees the updated value.
    assign take = clk_en && hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_reg     <= PCG_APHASE_RST;
            hready_reg <= 1'b1;
            hrdata_reg <= PCG_RDATA_RST;
            hresp_reg  <= 1'b0;
        end else if (clk_en) begin
            ap_reg.wr <= take && hwrite;
            ap_reg.rd <= take && !hwrite;
            if (take) begin
                ap_reg.addr <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hready_reg <= 1'b0;
            end else if (ap_reg.rd) begin
                hready_reg <= 1'b1;
                hrdata_reg <= rd_val;
            end
            hresp_reg <= 1'b0;
        end
    end

    always_comb begin
        we_ctrl = 1'b0;
        we_poly = 1'b0;
        we_data = 1'b0;
        we_seed = 1'b0;
        we_clr  = 1'b0;
        we_en   = 1'b0;
        if (ap_reg.wr && ap_reg.addr == PCG_OFS_CTRL) begin
            we_ctrl = 1'b1;
        end else if (ap_reg.wr && ap_reg.addr == PCG_OFS_POLY) begin
            we_poly = 1'b1;
        end else if (ap_reg.wr && ap_reg.addr == PCG_OFS_DATA) begin
            we_data = 1'b1;
        end else if (ap_reg.wr && ap_reg.addr == PCG_OFS_SEED) begin
            we_seed = 1'b1;
        end else if (ap_reg.wr && ap_reg.addr == PCG_OFS_IRQ_CLR) begin
            we_clr = 1'b1;
        end else if (ap_reg.wr && ap_reg.addr == PCG_OFS_IRQ_EN) begin
            we_en = 1'b1;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (ap_reg.addr == PCG_OFS_CTRL) begin
            rd_val[PCG_IDLE_BIT]        = ctrl_reg.idle_halt_select;
            rd_val[PCG_CNT_LSB +: 5]    = count_reg;
            rd_val[PCG_FULL_BIT]        = full;
            rd_val[PCG_EMPTY_BIT]       = empty;
            rd_val[PCG_RUN_BIT]         = ctrl_reg.shifter_run;
            rd_val[PCG_PLEN_LSB +: 4]   = ctrl_reg.poly_length_minus_one;
        end else if (ap_reg.addr == PCG_OFS_POLY) begin
            rd_val[15:0] = poly_reg;
        end else if (ap_reg.addr == PCG_OFS_DATA || ap_reg.addr == PCG_OFS_SEED) begin
            rd_val[15:0] = crc_reg;
        end else if (ap_reg.addr == PCG_OFS_IRQ_STS) begin
            rd_val[PCG_IRQ_DRAIN] = irq_sts_reg[0];
        end else if (ap_reg.addr == PCG_OFS_IRQ_EN) begin
            rd_val[PCG_IRQ_DRAIN] = irq_en_reg[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= PCG_CTRL_RST;
            poly_reg <= PCG_POLY_RST;
        end else if (clk_en) begin
            if (we_ctrl) begin
                ctrl_reg.idle_halt_select      <= hwdata[PCG_IDLE_BIT];
                ctrl_reg.shifter_run           <= hwdata[PCG_RUN_BIT];
                ctrl_reg.poly_length_minus_one <= hwdata[PCG_PLEN_LSB +: 4];
            end
            if (we_poly) begin
                poly_reg <= hwdata[15:0] & PCG_TAP_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO and shifter. Everything here freezes with the power state; a data
    // write that arrives while frozen is dropped, since no core state may move.
    assign plen = ctrl_reg.poly_length_minus_one;
    assign run_en = clk_en && !sleep_mode && !(idle_mode && ctrl_reg.idle_halt_select);
    assign full   = (count_reg == fifo_max(plen));
    assign empty  = (count_reg == PCG_CNT_RST);
    assign advance = run_en && (ctrl_reg.shifter_run || active_reg) && !empty;
    assign pop     = advance && (bit_idx_reg == plen);
    assign push    = run_en && we_data;
    assign wrap    = push && full;
    assign drain_evt = pop && (count_reg == 5'h01) && !push;
    assign din     = fifo_mem[rd_ptr_reg][4'(plen - bit_idx_reg)];

    always_comb begin
        if (wrap) begin
            count_next = PCG_CNT_RST;
        end else begin
            count_next = 5'(count_reg + {4'h0, push} - {4'h0, pop});
        end
    end

    always_ff @(posedge hclk) begin
        if (push && !wrap) begin
            fifo_mem[wr_ptr_reg] <= hwdata[15:0] & plen_mask(plen);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg  <= 4'h0;
            rd_ptr_reg  <= 4'h0;
            count_reg   <= PCG_CNT_RST;
            bit_idx_reg <= 4'h0;
            active_reg  <= 1'b0;
        end else if (run_en) begin
            count_reg  <= count_next;
            active_reg <= ctrl_reg.shifter_run || (active_reg && count_next != PCG_CNT_RST);
            if (wrap) begin
                wr_ptr_reg  <= 4'h0;
                rd_ptr_reg  <= 4'h0;
                bit_idx_reg <= 4'h0;
            end else begin
                if (push) begin
                    wr_ptr_reg <= 4'(wr_ptr_reg + 4'h1);
                end
                if (pop) begin
                    rd_ptr_reg  <= 4'(rd_ptr_reg + 4'h1);
                    bit_idx_reg <= 4'h0;
                end else if (advance) begin
                    bit_idx_reg <= 4'(bit_idx_reg + 4'h1);
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_reg <= PCG_CRC_RST;
        end else if (run_en) begin
            if (we_seed) begin
                crc_reg <= hwdata[15:0] & plen_mask(plen);
            end else if (advance) begin
                crc_reg <= lfsr_step(crc_reg, poly_reg, plen, din);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts run on clk_en only, so an event stays visible while frozen.
    // sticky drain flag, set beats clear
    assign irq_sts_next = (irq_sts_reg & ~(we_clr ? hwdata[0:0] : 1'b0)) | drain_evt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_sts_reg <= 1'b0;
            irq_en_reg  <= 1'b0;
            irq_reg     <= 1'b0;
        end else if (clk_en) begin
            irq_sts_reg <= irq_sts_next;
            if (we_en) begin
                irq_en_reg <= hwdata[0:0];
            end
            irq_reg <= |(irq_sts_next & (we_en ? hwdata[0:0] : irq_en_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_DRAIN_IRQ: assert property (drain_evt && clk_en |=> irq_sts_reg[0])
        else $error("drain did not set status");
    AST_SLEEP_FREEZE: assert property (sleep_mode |=> $stable(count_reg)
        && $stable(crc_reg) && $stable(bit_idx_reg))
        else $error("core moved during sleep");
    AST_IDLE_RUN: assert property (clk_en && idle_mode && !sleep_mode
        && !ctrl_reg.idle_halt_select && ctrl_reg.shifter_run && !empty && !wrap
        |=> !($stable(bit_idx_reg) && $stable(rd_ptr_reg)))
        else $error("core frozen in idle without halt");
    AST_IDLE_IRQ: assert property (idle_mode && ctrl_reg.idle_halt_select && clk_en
        && irq_sts_reg[0] && irq_en_reg[0] && !we_clr && !we_en |=> crc_irq)
        else $error("interrupt lost while halted");
    AST_COUNT_MAX: assert property (count_reg <= fifo_max(plen))
        else $error("word count above maximum");
    AST_FULL_FLAG: assert property (we_data && run_en && !full && !pop
        && count_reg == 5'(fifo_max(plen) - 5'h01) |=> full)
        else $error("full flag not raised");
    AST_EMPTY_FLAG: assert property (drain_evt |=> empty && !full)
        else $error("empty flag not raised");
    AST_WRAP: assert property (wrap |=> count_reg == 5'h00 && !$rose(irq_sts_reg[0]))
        else $error("overfill did not wrap quietly");
    AST_POP_STEP: assert property (pop && !push |=> bit_idx_reg == 4'h0
        && count_reg == 5'($past(count_reg) - 5'h01))
        else $error("word not popped after last bit");
    AST_TAP0: assert property (poly_reg[0] == 1'b0)
        else $error("tap bit 0 stored");
    COV_DRAIN: cover property (drain_evt ##1 crc_irq);
    COV_WRAP: cover property (wrap);
    COV_IDLE_HALT: cover property (idle_mode && ctrl_reg.idle_halt_select && !empty);
    COV_STOP_DRAIN: cover property (active_reg && !ctrl_reg.shifter_run && pop);

endmodule

// [bench/pcg_tb.sv]
// Self-checking bench for the CRC generator: AHB-Lite tasks and directed tests.
// Assumes one slave, so hready is fed back from hreadyout.
`timescale 1ns/1ps

module testbench;
    import pcg_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        sleep_mode;
    logic        idle_mode;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        crc_irq;
    logic [31:0] rd;
    int          n_fail;
    int          n_checks;

    pcg_top uut (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (1'h1),
        .sleep_mode (sleep_mode),
        .idle_mode  (idle_mode),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (3'h2),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .crc_irq    (crc_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Samples just after the edge, so the pre-edge value is seen
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'h1 && k < 50);
        if (hreadyout !== 1'h1) begin
            chk_bit(hreadyout, 1'h1);
            tally_and_finish();
        end
    endtask

    // Entered right after a rising edge; returns right after one
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        wait_ready();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk_bit(hresp, 1'h0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        chk_word(rd, exp);
    endtask

    task automatic wait_empty();
        int k;
        k = 0;
        do begin
            bus(1'h0, PCG_OFS_CTRL, 32'h0);
            k++;
        end while (rd[PCG_EMPTY_BIT] !== 1'h1 && k < 100);
        chk_bit(rd[PCG_EMPTY_BIT], 1'h1);
        if (rd[PCG_EMPTY_BIT] !== 1'h1) begin
            tally_and_finish();
        end
    endtask

    // Reference shift: MSB first, x^0 always fed back
    function automatic logic [15:0] crc_model(input logic [15:0] crc, input logic [15:0] taps,
                                              input logic [3:0] pl, input logic [15:0] d);
        int   i;
        logic fb;
        for (i = pl; i >= 0; i--) begin
            fb = crc[pl] ^ d[i];
            crc = (crc << 1) ^ (fb ? {taps[15:1], 1'h1} : 16'h0);
            crc = crc & (16'hffff >> (15 - pl));
        end
        return crc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic fill_case(input logic [3:0] pl);
        int depth;
        int i;
        depth = (pl > 4'h7) ? 8 : 16;
        bus(1'h1, PCG_OFS_CTRL, {28'h0, pl});
        for (i = 1; i <= depth; i++) begin
            bus(1'h1, PCG_OFS_DATA, 32'h5a);
            rd_chk(PCG_OFS_CTRL, {19'h0, i[4:0], i == depth, 3'h0, pl});
        end
        bus(1'h1, PCG_OFS_DATA, 32'h5a);
        rd_chk(PCG_OFS_CTRL, {28'h4, pl});
        rd_chk(PCG_OFS_IRQ_STS, 32'h0);
        $display("fill test length %0d done", pl + 1);
    endtask

    // frz: 0 none, 1 sleep, 2 idle with halt, 3 idle without halt
    task automatic crc_case(input logic [3:0] pl, input logic [15:0] taps,
                            input logic [15:0] seed, input logic [15:0] w0,
                            input logic [15:0] w1, input int frz);
        logic [31:0] ctl;
        logic [15:0] crc;
        logic        held;
        held = (frz == 1 || frz == 2);
        ctl = {16'h0, 2'h0, frz == 2, 9'h0, pl};
        bus(1'h1, PCG_OFS_CTRL, ctl);
        bus(1'h1, PCG_OFS_POLY, {16'h0, taps});
        bus(1'h1, PCG_OFS_SEED, {16'h0, seed});
        bus(1'h1, PCG_OFS_DATA, {16'h0, w0});
        bus(1'h1, PCG_OFS_DATA, {16'h0, w1});
        repeat (20) @(posedge hclk);
        rd_chk(PCG_OFS_CTRL, ctl | 32'h200);
        sleep_mode <= (frz == 1);
        idle_mode  <= (frz >= 2);
        bus(1'h1, PCG_OFS_CTRL, ctl | 32'h10);
        if (!held) begin
            bus(1'h1, PCG_OFS_CTRL, ctl);
        end
        repeat (40) @(posedge hclk);
        rd_chk(PCG_OFS_CTRL, held ? (ctl | 32'h210) : (ctl | 32'h40));
        sleep_mode <= 1'h0;
        idle_mode  <= 1'h0;
        wait_empty();
        bus(1'h1, PCG_OFS_CTRL, ctl);
        idle_mode  <= (frz == 2);
        crc = crc_model(crc_model(seed, taps, pl, w0), taps, pl, w1);
        rd_chk(PCG_OFS_DATA, {16'h0, crc});
        rd_chk(PCG_OFS_IRQ_STS, 32'h1);
        chk_bit(crc_irq, 1'h1);
        if (frz == 0) begin
            bus(1'h1, PCG_OFS_IRQ_EN, 32'h0);
            rd_chk(PCG_OFS_IRQ_EN, 32'h0);
            chk_bit(crc_irq, 1'h0);
            bus(1'h1, PCG_OFS_IRQ_EN, 32'h1);
        end
        bus(1'h1, PCG_OFS_IRQ_CLR, 32'h1);
        rd_chk(PCG_OFS_IRQ_STS, 32'h0);
        chk_bit(crc_irq, 1'h0);
        idle_mode  <= 1'h0;
        $display("crc test mode %0d length %0d done", frz, pl + 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'h0;
        forever #2.5 hclk = ~hclk;
    end

    initial begin
        hresetn    = 1'h0;
        sleep_mode = 1'h0;
        idle_mode  = 1'h0;
        hsel       = 1'h0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'h0;
        hwdata     = 32'h0;
        n_fail     = 0;
        n_checks   = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        chk_bit(crc_irq, 1'h0);
        rd_chk(PCG_OFS_CTRL, 32'h40);
        rd_chk(PCG_OFS_POLY, 32'h0);
        rd_chk(8'h1c, 32'h0);
        bus(1'h1, PCG_OFS_CTRL, 32'hffff);
        rd_chk(PCG_OFS_CTRL, 32'h205f);
        bus(1'h1, PCG_OFS_POLY, 32'hffff);
        rd_chk(PCG_OFS_POLY, 32'hfffe);
        bus(1'h1, PCG_OFS_CTRL, 32'h0);
        $display("register test done");
        fill_case(4'h7);
        fill_case(4'h8);
        bus(1'h1, PCG_OFS_IRQ_EN, 32'h1);
        crc_case(4'hf, 16'h1020, 16'hffff, 16'h3132, 16'h3334, 0);
        crc_case(4'h7, 16'h0006, 16'h0000, 16'h00a5, 16'h003c, 1);
        crc_case(4'h4, 16'h000c, 16'h0011, 16'h0015, 16'h000a, 2);
        crc_case(4'hb, 16'h0810, 16'h0000, 16'h0abc, 16'h0123, 3);
        tally_and_finish();
    end

endmodule
